/* lwm_sram_write_mask.sv */
// Operation
// - x8/x18 both selects low: full word written
// - Select0 only: low lane written
// - Select1 only: high lane written
// - x8/x18 both high: nothing written
// - x9 single select gates 9 bits
// - x36 all selects low: 36 bits
// - x36 four 9-bit lanes, one select each
// - x9/x36 all high: no write
// - Mask sampled per clock edge separately
// - Data captured on both clock rises
// - Read out on C pair, else K
// - Powers up deselected, outputs off
// - Burst address order per variant
// - Timing counted from start cycle t
`timescale 1ns/10ps
`default_nettype none
`include "lwm_defines.svh"
module lwm_sram_write_mask
  import lwm_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  input  wire logic      clk_en,
  input  wire logic [1:0] variant_strap,
  input  wire logic      k_clk_pin,
  input  wire logic      k_clk_n_pin,
  input  wire logic      c_clk_pin,
  input  wire logic      c_clk_n_pin,
  input  wire logic      load_strobe_n,
  input  wire logic      rw_sel,
  input  wire lwm_pkg::lwm_addr_t addr_pin,
  input  wire lwm_pkg::lwm_word_t data_in_pin,
  input  wire lwm_pkg::lwm_sel_t  lane_write_select_n,
  output lwm_pkg::lwm_word_t      data_out,
  output lwm_pkg::lwm_word_t      data_out_oe,
  output logic           single_clock_mode
);
  import lwm_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // All pins share the same two-stage delay, so data stays aligned with its clock edge
  localparam int PW = 4 + 2 + `LWM_ADDR_W + `LWM_DATA_W + `LWM_SEL_W + 2;
  logic [PW-1:0] s1_q, s1_d, s2_q, s2_d;
  logic          k_prev_q, k_prev_d, kn_prev_q, kn_prev_d;
  logic          c_prev_q, c_prev_d, cn_prev_q, cn_prev_d;

  logic          k_s, kn_s, c_s, cn_s, ld_n_s, rw_s;
  lwm_addr_t     addr_s;
  lwm_word_t     data_s;
  lwm_sel_t      sel_s;
  logic [1:0]    var_s;

  always_comb
  begin
    s1_d = {k_clk_pin, k_clk_n_pin, c_clk_pin, c_clk_n_pin, load_strobe_n, rw_sel,
            addr_pin, data_in_pin, lane_write_select_n, variant_strap};
    s2_d = s1_q;
    {k_s, kn_s, c_s, cn_s, ld_n_s, rw_s, addr_s, data_s, sel_s, var_s} = s2_q;
    k_prev_d  = k_s;
    kn_prev_d = kn_s;
    c_prev_d  = c_s;
    cn_prev_d = cn_s;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q      <= '0;
      s2_q      <= '0;
      k_prev_q  <= 1'b0;
      kn_prev_q <= 1'b0;
      c_prev_q  <= 1'b0;
      cn_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_q      <= s1_d;
      s2_q      <= s2_d;
      k_prev_q  <= k_prev_d;
      kn_prev_q <= kn_prev_d;
      c_prev_q  <= c_prev_d;
      cn_prev_q <= cn_prev_d;
    end
  end

  logic k_rise, kn_rise, o_rise, on_rise;

  // ----------------------------------------
  // Straps and clock selection
  // ----------------------------------------
  logic [1:0]   strap_cnt_q, strap_cnt_d;
  logic         strap_done_q, strap_done_d;
  logic         single_q, single_d;
  lwm_variant_e variant_q, variant_d;

  always_comb
  begin
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    single_d     = single_q;
    variant_d    = variant_q;
    if (!strap_done_q)
    begin
      if (strap_cnt_q == `LWM_STRAP_WAIT)
      begin
        strap_done_d = 1'b1;
        single_d     = c_s & cn_s;
        variant_d    = lwm_variant_e'(var_s);
      end
      else
        strap_cnt_d = strap_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      single_q     <= 1'b0;
      variant_q    <= LWM_X8;
    end
    else if (clk_en)
    begin
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      single_q     <= single_d;
      variant_q    <= variant_d;
    end
  end

  always_comb
  begin
    k_rise  = strap_done_q & k_s & ~k_prev_q;
    kn_rise = strap_done_q & kn_s & ~kn_prev_q;
    o_rise  = single_q ? k_rise  : (strap_done_q & c_s & ~c_prev_q);
    on_rise = single_q ? kn_rise : (strap_done_q & cn_s & ~cn_prev_q);
  end

  // ----------------------------------------
  // Burst control and array
  // ----------------------------------------
  lwm_state_e state_q, state_d;
  lwm_addr_t  a1_q, a1_d, a2_q, a2_d;
  lwm_word_t  mem_q [`LWM_DEPTH];
  lwm_word_t  mem_d [`LWM_DEPTH];
  lwm_word_t  dout_q, dout_d, oe_q, oe_d;
  lwm_addr_t  wr_addr;
  logic       wr_go;

  lwm_mask_if mif ();

  lwm_lane_merge u_merge (
    .mif (mif)
  );

  always_comb
  begin
    state_d = state_q;
    a1_d    = a1_q;
    a2_d    = a2_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    wr_addr = a1_q;
    wr_go   = 1'b0;
    case (state_q)
      LWM_IDLE:
        if (k_rise && !ld_n_s)
        begin
          if (variant_q == LWM_X8 || variant_q == LWM_X9)
          begin
            a1_d = {addr_s[`LWM_ADDR_W-1:1], 1'b0};
            a2_d = {addr_s[`LWM_ADDR_W-1:1], 1'b1};
          end
          else
          begin
            a1_d = addr_s;
            a2_d = {addr_s[`LWM_ADDR_W-1:1], ~addr_s[0]};
          end
          state_d = rw_s ? LWM_RD1 : LWM_WR1;
        end
      LWM_WR1:
        if (k_rise)
        begin
          wr_go   = 1'b1;
          wr_addr = a1_q;
          state_d = LWM_WR2;
        end
      LWM_WR2:
        if (kn_rise)
        begin
          wr_go   = 1'b1;
          wr_addr = a2_q;
          state_d = LWM_IDLE;
        end
      LWM_RD1:
        if (on_rise)
        begin
          dout_d  = mem_q[a1_q];
          oe_d    = '1;
          state_d = LWM_RD2;
        end
      LWM_RD2:
        if (o_rise)
        begin
          dout_d  = mem_q[a2_q];
          state_d = LWM_RD_END;
        end
      LWM_RD_END:
        if (o_rise)
        begin
          oe_d    = '0;
          state_d = LWM_IDLE;
        end
      default:
        state_d = LWM_IDLE;
    endcase
  end

  always_comb
  begin
    mif.variant  = variant_q;
    // Mask taken on this edge only
    mif.sel_n    = sel_s;
    mif.new_data = data_s;
    mif.old_data = mem_q[wr_addr];
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LWM_DEPTH; gi++)
    begin : g_mem
      always_comb
      begin
        mem_d[gi] = mem_q[gi];
        if (wr_go && mif.wr_en && wr_addr == lwm_addr_t'(gi))
          mem_d[gi] = mif.merged;
      end

      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          mem_q[gi] <= '0;
        else if (clk_en)
          mem_q[gi] <= mem_d[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= LWM_IDLE;
      a1_q    <= '0;
      a2_q    <= '0;
      dout_q  <= '0;
      oe_q    <= '0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      a1_q    <= a1_d;
      a2_q    <= a2_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
    end
  end

  assign data_out          = dout_q;
  assign data_out_oe       = oe_q;
  assign single_clock_mode = single_q;
endmodule // lwm_sram_write_mask
`default_nettype wire

/* lwm_defines.svh */
`ifndef LWM_DEFINES_SVH
`define LWM_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define LWM_DATA_W     36
`define LWM_SEL_W      4
`define LWM_ADDR_W     4
`define LWM_DEPTH      16
`define LWM_LANE_W     9
`define LWM_NIB_W      4

// ----------------------------------------
// Strap handling
// ----------------------------------------
`define LWM_STRAP_WAIT 2'h3

`endif

/* lwm_pkg.sv */
package lwm_pkg;
  `include "lwm_defines.svh"

  typedef logic [`LWM_DATA_W-1:0] lwm_word_t;
  typedef logic [`LWM_SEL_W-1:0]  lwm_sel_t;
  typedef logic [`LWM_ADDR_W-1:0] lwm_addr_t;

  typedef enum logic [1:0] {
    LWM_X8,
    LWM_X9,
    LWM_X18,
    LWM_X36
  } lwm_variant_e;

  typedef enum logic [2:0] {
    LWM_IDLE,
    LWM_WR1,
    LWM_WR2,
    LWM_RD1,
    LWM_RD2,
    LWM_RD_END
  } lwm_state_e;
endpackage

/* lwm_mask_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface lwm_mask_if;
  import lwm_pkg::*;
  lwm_variant_e variant;
  lwm_sel_t     sel_n;
  lwm_word_t    new_data;
  lwm_word_t    old_data;
  lwm_word_t    merged;
  logic         wr_en;

  modport ctrl (output variant, output sel_n, output new_data, output old_data, input merged, input wr_en);
  modport unit (input variant, input sel_n, input new_data, input old_data, output merged, output wr_en);
endinterface
`default_nettype wire

/* lwm_lane_merge.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lwm_defines.svh"
module lwm_lane_merge
  import lwm_pkg::*;
(
  lwm_mask_if.unit mif
);
  import lwm_pkg::*;

  // ----------------------------------------
  // Bit enables from lane selects
  // ----------------------------------------
  function automatic lwm_word_t lane_enable(input lwm_variant_e v, input lwm_sel_t s);
    lwm_word_t en;
    en = '0;
    case (v)
      LWM_X8:
      begin
        en[`LWM_NIB_W-1:0] = {`LWM_NIB_W{~s[0]}};
        en[2*`LWM_NIB_W-1:`LWM_NIB_W] = {`LWM_NIB_W{~s[1]}};
      end
      LWM_X9:
        en[`LWM_LANE_W-1:0] = {`LWM_LANE_W{~s[0]}};
      LWM_X18:
        for (int i = 0; i < 2; i++)
          en[i*`LWM_LANE_W +: `LWM_LANE_W] = {`LWM_LANE_W{~s[i]}};
      LWM_X36:
        for (int i = 0; i < `LWM_SEL_W; i++)
          en[i*`LWM_LANE_W +: `LWM_LANE_W] = {`LWM_LANE_W{~s[i]}};
      default:
        en = '0;
    endcase
    return en;
  endfunction

  lwm_word_t en_w;

  always_comb
  begin
    en_w = lane_enable(mif.variant, mif.sel_n);
  end

  assign mif.merged = (mif.new_data & en_w) | (mif.old_data & ~en_w);
  assign mif.wr_en  = |en_w;
endmodule // lwm_lane_merge
`default_nettype wire

/* lwm_props.sv */
`timescale 1ns/10ps
`default_nettype none
module lwm_props
  import lwm_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rst_b,
  input wire logic      k_clk_pin,
  input wire logic      k_clk_n_pin,
  input wire logic      c_clk_pin,
  input wire logic      c_clk_n_pin,
  input wire lwm_word_t data_out,
  input wire lwm_word_t data_out_oe,
  input wire logic      single_clock_mode
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_oe_on;
    $rose(data_out_oe[0]);
  endsequence
  a_oe_uniform: assert property (data_out_oe == '0 || data_out_oe == '1)
    else $error("oe bits differ");
  // Pins reach the state logic three edges late, so look back exactly that far
  a_oe_after_cn: assert property (s_oe_on |->
    (single_clock_mode ? $past(k_clk_n_pin, 3) : $past(c_clk_n_pin, 3))) else $error("oe on without clock");
  a_oe_off_c: assert property ($fell(data_out_oe[0]) |->
    (single_clock_mode ? $past(k_clk_pin, 3) : $past(c_clk_pin, 3))) else $error("oe off without clock");
  a_oe_holds: assert property (s_oe_on |-> data_out_oe[0] [*4])
    else $error("oe dropped early");
  a_dout_on_clk: assert property ($changed(data_out) |->
    (single_clock_mode ? ($past(k_clk_pin, 3) || $past(k_clk_n_pin, 3))
                       : ($past(c_clk_pin, 3) || $past(c_clk_n_pin, 3))))
    else $error("data moved off clock");
  a_rst_quiet: assert property (disable iff (1'h0) !rst_b |-> data_out_oe == '0 && data_out == '0)
    else $error("driving in reset");
  a_boot_quiet: assert property ($rose(rst_b) |-> (data_out_oe == '0) [*8])
    else $error("driving after reset");
  a_mode_steady: assert property (!$fell(single_clock_mode))
    else $error("mode changed");
endmodule // lwm_props
`default_nettype wire

/* lwm_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lwm_ctrl_model
  import lwm_pkg::*;
(
  input  wire logic      sys_clk,
  output logic           k,
  output logic           kn,
  output logic           c,
  output logic           cn,
  output logic           ld_n,
  output logic           rw,
  output lwm_addr_t      ad,
  output lwm_word_t      d,
  output lwm_sel_t       sel_n,
  input  wire lwm_word_t q,
  input  wire lwm_word_t oe
);
  lwm_word_t q1, q2, oe1, oe2;
  initial
  begin
    {k, kn, c, cn, rw, ad, d} = '0;
    ld_n = 1'h1;
    sel_n = '1;
  end
  // Six edges per level so the pin sync sees it
  task st;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wr(input lwm_addr_t a, input lwm_word_t w1, w2, input lwm_sel_t s1, s2);
    ld_n <= 1'h0;
    rw <= 1'h0;
    ad <= a;
    st;
    k <= 1'h1;
    st;
    k <= 1'h0;
    ld_n <= 1'h1;
    ad <= ~a;
    d <= w1;
    sel_n <= s1;
    st;
    k <= 1'h1;
    st;
    k <= 1'h0;
    d <= w2;
    sel_n <= s2;
    st;
    kn <= 1'h1;
    st;
    kn <= 1'h0;
    d <= ~w2;
    sel_n <= '1;
    st;
  endtask
  // output clocks high at power-on pick single mode
  task park(input logic one);
    c <= one;
    cn <= one;
  endtask
  // Single mode reads on the input pair, else on the output pair
  task oclk(input logic one, neg, v);
    if (one && neg)
      kn <= v;
    else if (one)
      k <= v;
    else if (neg)
      cn <= v;
    else
      c <= v;
  endtask
  task automatic rd(input lwm_addr_t a, input logic one);
    ld_n <= 1'h0;
    rw <= 1'h1;
    ad <= a;
    st;
    k <= 1'h1;
    st;
    k <= 1'h0;
    ld_n <= 1'h1;
    ad <= ~a;
    st;
    oclk(one, 1'h1, 1'h1);
    st;
    q1 = q;
    oe1 = oe;
    oclk(one, 1'h1, 1'h0);
    st;
    oclk(one, 1'h0, 1'h1);
    st;
    q2 = q;
    oclk(one, 1'h0, 1'h0);
    st;
    oclk(one, 1'h0, 1'h1);
    st;
    oe2 = oe;
    oclk(one, 1'h0, 1'h0);
    st;
  endtask
endmodule // lwm_ctrl_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lwm_pkg::*;
  localparam lwm_word_t A = 36'hA5A5A5A5A;
  localparam lwm_word_t B = 36'h5A5A5A5A5;
  localparam lwm_word_t C = 36'h123456789;
  localparam lwm_word_t D = 36'hFEDCBA987;
  logic       sys_clk = 1'h0;
  // Starts high so the first drive low is a real edge for the async reset
  logic       rst_b = 1'h1;
  logic       strap_one = 1'h0;
  logic [1:0] strap = 2'h0;
  logic       k, kn, c, cn, ld_n, rw, single;
  lwm_addr_t  ad;
  lwm_word_t  d, q, oe;
  lwm_sel_t   sel_n;
  int         errors = 0;
  int         comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  lwm_ctrl_model u_ctl (.sys_clk(sys_clk), .k(k), .kn(kn), .c(c), .cn(cn), .ld_n(ld_n), .rw(rw), .ad(ad),
    .d(d), .sel_n(sel_n), .q(q), .oe(oe));
  lwm_sram_write_mask DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'h1), .variant_strap(strap),
    .k_clk_pin(k), .k_clk_n_pin(kn), .c_clk_pin(c), .c_clk_n_pin(cn), .load_strobe_n(ld_n), .rw_sel(rw),
    .addr_pin(ad), .data_in_pin(d), .lane_write_select_n(sel_n), .data_out(q), .data_out_oe(oe),
    .single_clock_mode(single));
  // ----
  // Helpers
  // ----
  task chk(input lwm_word_t got, exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Straps are caught only at reset release, so each variant reboots
  task boot(input logic [1:0] v);
    rst_b <= 1'h0;
    strap <= v;
    u_ctl.park(strap_one);
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk(oe, '0);
    chk({35'h0, single}, {35'h0, strap_one});
  endtask
  task run(input logic [1:0] v, input lwm_sel_t s1, s2, input lwm_word_t m, e1, e2);
    boot(v);
    u_ctl.wr(4'h5, A, B, 4'h0, 4'h0);
    u_ctl.wr(4'h5, C, D, s1, s2);
    u_ctl.rd(4'h5, strap_one);
    chk(u_ctl.q1 & m, e1 & m);
    chk(u_ctl.q2 & m, e2 & m);
    chk(u_ctl.oe1, '1);
    chk(u_ctl.oe2, '0);
  endtask
  // ----
  // Scenarios
  // ----
  task t_x18_split;
    run(2'h2, 4'hE, 4'hD, 36'h3FFFF, (A & ~36'h1FF) | (C & 36'h1FF), (B & 36'h1FF) | (D & ~36'h1FF));
  endtask
  task t_x18_none;
    run(2'h2, 4'hF, 4'hF, 36'h3FFFF, A, B);
  endtask
  task t_x8_nib;
    run(2'h0, 4'hE, 4'hD, 36'hFF, (A & ~36'hF) | (C & 36'hF), (B & ~36'hF0) | (D & 36'hF0));
  endtask
  task t_x9_gate;
    run(2'h1, 4'hE, 4'hF, 36'h1FF, C, B);
  endtask
  task t_x36_lane;
    run(2'h3, 4'hB, 4'hD, '1, (A & ~36'h7FC0000) | (C & 36'h7FC0000), (B & ~36'h3FE00) | (D & 36'h3FE00));
  endtask
  task t_x36_full;
    run(2'h3, 4'h6, 4'h0, '1, (A & ~36'hFF80001FF) | (C & 36'hFF80001FF), D);
  endtask
  // Runs last, so no later boot has to take the output clocks low again
  task t_x36_single;
    strap_one = 1'h1;
    run(2'h3, 4'h0, 4'hF, '1, C, B);
  endtask
  initial
  begin
    t_x18_split;
    t_x18_none;
    t_x8_nib;
    t_x9_gate;
    t_x36_lane;
    t_x36_full;
    t_x36_single;
    print_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    print_verdict;
  end
endmodule // tb_top
bind lwm_sram_write_mask lwm_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .k_clk_pin(k_clk_pin),
  .k_clk_n_pin(k_clk_n_pin), .c_clk_pin(c_clk_pin), .c_clk_n_pin(c_clk_n_pin), .data_out(data_out),
  .data_out_oe(data_out_oe), .single_clock_mode(single_clock_mode));
`default_nettype wire
